// File: hw/sss_spi_slave.v
// SPI slave with semaphore-shared RAM buffers
`timescale 1ns/10ps
`include "sss_defs.vh"
// Function
// - All four clock modes chosen by polarity and phase; master must match.
// - Transmit channel reads RAM bytes, receive channel writes received bytes.
// - Receive limit above transmit limit: over-read fill after transmit buffer ends.
// - Transaction done raised only after all RAM accesses finished.
// - CPU requests semaphore, waits for grant, gives it back afterwards.
// - Give task returns semaphore from CPU; no effect when CPU lacks it.
// - Semaphore never blocks CPU access to pointers or RAM.
// - On enable CPU owns semaphore with no granted event.
// - Request while CPU owns semaphore raises granted event at once.
// - Select fall tries semaphore; failure ignores whole transaction with ignored fill.
// - Simultaneous CPU and slave requests: CPU wins.
// - Granted transaction stores received bytes, shifts out transmit bytes.
// - Granted transaction end releases semaphore and raises done event.
// - Free semaphore allows back-to-back transactions reusing same pointers.
// - Done-to-CPU shortcut hands semaphore to CPU after each granted transaction.
// - CPU request during slave ownership stays pending until slave releases.
// - Shortcut plus pending CPU request serves only one request after done.
// - Bytes beyond receive limit set receive-excess flag and are discarded.
// - Bytes beyond transmit limit set transmit-excess flag and send over-read fill.
// - Byte counters updated at granted end; fills excluded, written bytes counted.
// - Receive-buffer-full event raised when receive buffer becomes full.
// - Excess flags cleared only by writing one to their bit.
// - Data-out stays undriven while chip select is high.
module sss_spi_slave #(
   parameter CNT_W = `SSS_CNT_W,
   parameter ADDR_W = `SSS_ADDR_W
) (
   input wire CORE_CLK,
   input wire NRST,
   input wire ENABLE,
   input wire CPOL,
   input wire CPHA,
   input wire LSB_FIRST,
   input wire END_ACQUIRE,
   input wire TASK_ACQUIRE,
   input wire TASK_RELEASE,
   input wire [ADDR_W-1:0] RX_BUFFER_POINTER,
   input wire [ADDR_W-1:0] TX_BUFFER_POINTER,
   input wire [CNT_W-1:0] RX_BUFFER_LIMIT,
   input wire [CNT_W-1:0] TX_BUFFER_LIMIT,
   input wire [7:0] IGNORED_FILL_CHARACTER,
   input wire [7:0] TX_EXCESS_FLAG_FILL_CHARACTER,
   input wire CLEAR_TX_EXCESS,
   input wire CLEAR_RX_EXCESS,
   input wire CSN,
   input wire SCK,
   input wire MOSI,
   output reg MISO_OUT,
   output reg MISO_OE,
   output reg [ADDR_W-1:0] MEM_ADDR,
   output reg MEM_RD,
   output reg MEM_WR,
   output reg [7:0] MEM_WDATA,
   input wire [7:0] MEM_RDATA,
   input wire MEM_ACK,
   output reg EVENT_END,
   output reg EVENT_ACQUIRED,
   output reg RX_BUFFER_FULL_EVENT,
   output reg [1:0] SEM_STATUS,
   output reg TX_EXCESS_FLAG,
   output reg RX_EXCESS_FLAG,
   output reg [CNT_W-1:0] RX_BYTE_COUNTER,
   output reg [CNT_W-1:0] TX_BYTE_COUNTER
);
   reg [1:0] csn_s, sck_s, mosi_s;
   reg sck_d, csn_d;
   reg [1:0] state;
   reg [1:0] sem;
   reg cpu_pending;
   reg [2:0] bit_cnt;
   reg [7:0] rx_shift, tx_shift;
   reg [CNT_W-1:0] rx_cnt, tx_cnt;
   reg rx_pend, tx_pend;
   reg [7:0] rx_hold;
   reg [7:0] tx_next;
   reg tx_next_ok;
   // Synchronised pin levels and their edges
   wire csn_n = csn_s[1];
   wire sck_n = sck_s[1];
   wire sel_fall = csn_d & ~csn_n;
   wire sel_rise = ~csn_d & csn_n;
   wire sck_rise = ~sck_d & sck_n;
   wire sck_fall = sck_d & ~sck_n;
   // Leading edge leaves idle level; sample edge picked by phase
   wire lead = CPOL ? sck_fall : sck_rise;
   wire trail = CPOL ? sck_rise : sck_fall;
   wire sample = CPHA ? trail : lead;
   wire shift = CPHA ? lead : trail;
   wire granted = state == `SSS_ST_GRANTED;
   wire mem_busy = MEM_RD | MEM_WR | rx_pend | tx_pend;
   // Receive shifter input and choice of the next transmit byte
   wire in_bit = mosi_s[1];
   wire [7:0] rx_byte = LSB_FIRST ? {in_bit, rx_shift[7:1]} : {rx_shift[6:0], in_bit};
   wire first_bit_next = LSB_FIRST ? tx_shift[0] : tx_shift[7];
   wire [7:0] load_byte = (tx_next_ok && tx_cnt < TX_BUFFER_LIMIT) ? tx_next : TX_EXCESS_FLAG_FILL_CHARACTER;

   // Two-flop synchronisers and edge history
   always @(posedge CORE_CLK or negedge NRST) begin
      if (!NRST) begin
         csn_s <= 2'h3;
         sck_s <= 2'h0;
         mosi_s <= 2'h0;
         csn_d <= 1'b1;
         sck_d <= 1'b0;
      end else begin
         csn_s <= {csn_s[0], CSN};
         sck_s <= {sck_s[0], SCK};
         mosi_s <= {mosi_s[0], MOSI};
         csn_d <= csn_s[1];
         sck_d <= sck_s[1];
      end
   end

   // Semaphore, transaction sequencing, shifting and memory channels
   always @(posedge CORE_CLK or negedge NRST) begin
      if (!NRST) begin
         state <= `SSS_ST_IDLE;
         sem <= `SSS_SEM_FREE;
         cpu_pending <= 1'b0;
         bit_cnt <= 3'h0;
         rx_shift <= `SSS_RST_BYTE;
         tx_shift <= `SSS_RST_BYTE;
         rx_cnt <= `SSS_RST_CNT;
         tx_cnt <= `SSS_RST_CNT;
         rx_pend <= 1'b0;
         tx_pend <= 1'b0;
         rx_hold <= `SSS_RST_BYTE;
         tx_next <= `SSS_RST_BYTE;
         tx_next_ok <= 1'b0;
         MISO_OUT <= 1'b0;
         MISO_OE <= 1'b0;
         MEM_ADDR <= {ADDR_W{1'b0}};
         MEM_RD <= 1'b0;
         MEM_WR <= 1'b0;
         MEM_WDATA <= `SSS_RST_BYTE;
         EVENT_END <= 1'b0;
         EVENT_ACQUIRED <= 1'b0;
         RX_BUFFER_FULL_EVENT <= 1'b0;
         SEM_STATUS <= `SSS_SEM_FREE;
         TX_EXCESS_FLAG <= 1'b0;
         RX_EXCESS_FLAG <= 1'b0;
         RX_BYTE_COUNTER <= `SSS_RST_CNT;
         TX_BYTE_COUNTER <= `SSS_RST_CNT;
      end else begin
         EVENT_END <= 1'b0;
         EVENT_ACQUIRED <= 1'b0;
         RX_BUFFER_FULL_EVENT <= 1'b0;
         // Flags clear on a write of one; a set in the same cycle wins below
         if (CLEAR_TX_EXCESS)
            TX_EXCESS_FLAG <= 1'b0;
         if (CLEAR_RX_EXCESS)
            RX_EXCESS_FLAG <= 1'b0;
         // Disabled: any transaction is dropped and the CPU holds the semaphore
         if (!ENABLE) begin
            state <= `SSS_ST_IDLE;
            sem <= `SSS_SEM_CPU;
            cpu_pending <= 1'b0;
            MEM_RD <= 1'b0;
            MEM_WR <= 1'b0;
            rx_pend <= 1'b0;
            tx_pend <= 1'b0;
            MISO_OE <= 1'b0;
         end else begin
            // CPU semaphore tasks; pointers and RAM stay open to the CPU regardless
            if (TASK_ACQUIRE) begin
               if (sem == `SSS_SEM_CPU || sem == `SSS_SEM_FREE) begin
                  sem <= `SSS_SEM_CPU;
                  EVENT_ACQUIRED <= 1'b1;
               end else
                  cpu_pending <= 1'b1;
            end else if (TASK_RELEASE && sem == `SSS_SEM_CPU)
               sem <= `SSS_SEM_FREE;
            case (state)
               `SSS_ST_IDLE: begin
                  if (sel_fall) begin
                     // Bit position and byte counts restart with every selection
                     bit_cnt <= 3'h0;
                     rx_cnt <= `SSS_RST_CNT;
                     tx_cnt <= `SSS_RST_CNT;
                     tx_next_ok <= 1'b0;
                     MISO_OE <= 1'b1;
                     // CPU request in the same cycle takes precedence
                     if (sem == `SSS_SEM_FREE && !TASK_ACQUIRE) begin
                        sem <= `SSS_SEM_SLAVE;
                        state <= `SSS_ST_GRANTED;
                        MEM_ADDR <= TX_BUFFER_POINTER;
                        MEM_RD <= (TX_BUFFER_LIMIT != `SSS_RST_CNT);
                        // Phase 0 needs a first bit before any clock edge; fill until RAM answers
                        tx_shift <= LSB_FIRST ? {1'b0, TX_EXCESS_FLAG_FILL_CHARACTER[7:1]}
                           : {TX_EXCESS_FLAG_FILL_CHARACTER[6:0], 1'b0};
                        MISO_OUT <= LSB_FIRST ? TX_EXCESS_FLAG_FILL_CHARACTER[0] : TX_EXCESS_FLAG_FILL_CHARACTER[7];
                     end else begin
                        state <= `SSS_ST_IGNORED;
                        tx_shift <= LSB_FIRST ? {1'b0, IGNORED_FILL_CHARACTER[7:1]}
                           : {IGNORED_FILL_CHARACTER[6:0], 1'b0};
                        MISO_OUT <= LSB_FIRST ? IGNORED_FILL_CHARACTER[0] : IGNORED_FILL_CHARACTER[7];
                     end
                  end
               end
               `SSS_ST_GRANTED, `SSS_ST_IGNORED: begin
                  if (sel_rise) begin
                     MISO_OE <= 1'b0;
                     state <= granted ? `SSS_ST_FINISH : `SSS_ST_IDLE;
                  end else begin
                     if (sample) begin
                        rx_shift <= rx_byte;
                        bit_cnt <= bit_cnt + 3'h1;
                        if (bit_cnt == 3'h7 && granted) begin
                           if (rx_cnt < RX_BUFFER_LIMIT) begin
                              rx_hold <= rx_byte;
                              rx_pend <= 1'b1;
                              rx_cnt <= rx_cnt + {{(CNT_W-1){1'b0}}, 1'b1};
                              if (rx_cnt + {{(CNT_W-1){1'b0}}, 1'b1} == RX_BUFFER_LIMIT)
                                 RX_BUFFER_FULL_EVENT <= 1'b1;
                           end else
                              RX_EXCESS_FLAG <= 1'b1;
                        end
                     end
                     if (shift) begin
                        // Byte boundary loads the next byte, else shift the current one
                        if (bit_cnt == 3'h0) begin
                           if (granted) begin
                              tx_shift <= LSB_FIRST ? {1'b0, load_byte[7:1]} : {load_byte[6:0], 1'b0};
                              MISO_OUT <= LSB_FIRST ? load_byte[0] : load_byte[7];
                              if (tx_next_ok && tx_cnt < TX_BUFFER_LIMIT) begin
                                 tx_cnt <= tx_cnt + {{(CNT_W-1){1'b0}}, 1'b1};
                                 tx_next_ok <= 1'b0;
                                 tx_pend <= 1'b1;
                              end else
                                 TX_EXCESS_FLAG <= 1'b1;
                           end else begin
                              tx_shift <= LSB_FIRST ? {1'b0, IGNORED_FILL_CHARACTER[7:1]}
                                 : {IGNORED_FILL_CHARACTER[6:0], 1'b0};
                              MISO_OUT <= LSB_FIRST ? IGNORED_FILL_CHARACTER[0] : IGNORED_FILL_CHARACTER[7];
                           end
                        end else begin
                           MISO_OUT <= first_bit_next;
                           tx_shift <= LSB_FIRST ? {1'b0, tx_shift[7:1]} : {tx_shift[6:0], 1'b0};
                        end
                     end
                  end
               end
               `SSS_ST_FINISH: begin
                  // Wait for memory channels to drain before signalling done
                  if (!mem_busy) begin
                     state <= `SSS_ST_IDLE;
                     EVENT_END <= 1'b1;
                     RX_BYTE_COUNTER <= rx_cnt;
                     TX_BYTE_COUNTER <= tx_cnt;
                     // One grant only: shortcut, pending and same-cycle requests merge
                     if (END_ACQUIRE || cpu_pending || TASK_ACQUIRE) begin
                        sem <= `SSS_SEM_CPU;
                        EVENT_ACQUIRED <= 1'b1;
                     end else
                        sem <= `SSS_SEM_FREE;
                     cpu_pending <= 1'b0;
                  end
               end
               default: state <= `SSS_ST_IDLE;
            endcase
            // Memory channel: one access at a time, write before read
            if (MEM_ACK && (MEM_RD || MEM_WR)) begin
               if (MEM_RD) begin
                  // Phase 0: the first byte goes straight to the pin before the first edge
                  if (!CPHA && granted && tx_cnt == `SSS_RST_CNT && bit_cnt == 3'h0) begin
                     tx_shift <= LSB_FIRST ? {1'b0, MEM_RDATA[7:1]} : {MEM_RDATA[6:0], 1'b0};
                     MISO_OUT <= LSB_FIRST ? MEM_RDATA[0] : MEM_RDATA[7];
                     tx_cnt <= tx_cnt + {{(CNT_W-1){1'b0}}, 1'b1};
                     tx_pend <= 1'b1;
                  end else begin
                     tx_next <= MEM_RDATA;
                     tx_next_ok <= 1'b1;
                  end
               end
               MEM_RD <= 1'b0;
               MEM_WR <= 1'b0;
            end else if (!MEM_RD && !MEM_WR) begin
               if (rx_pend) begin
                  rx_pend <= 1'b0;
                  MEM_WR <= 1'b1;
                  MEM_WDATA <= rx_hold;
                  // Write address is that of the byte just counted
                  MEM_ADDR <= RX_BUFFER_POINTER + {{(ADDR_W-CNT_W){1'b0}}, rx_cnt} - {{(ADDR_W-1){1'b0}}, 1'b1};
               end else if (tx_pend) begin
                  tx_pend <= 1'b0;
                  if (tx_cnt < TX_BUFFER_LIMIT && state == `SSS_ST_GRANTED) begin
                     MEM_RD <= 1'b1;
                     MEM_ADDR <= TX_BUFFER_POINTER + {{(ADDR_W-CNT_W){1'b0}}, tx_cnt};
                  end
               end
            end
         end
         SEM_STATUS <= sem;
      end
   end
endmodule // sss_spi_slave

// File: hw/sss_defs.vh
// Constants for the SPI slave with semaphore and memory access
`ifndef SSS_DEFS_VH
`define SSS_DEFS_VH
`define SSS_BYTE_BITS 8
`define SSS_BIT_CNT_W 3
`define SSS_CNT_W 15
`define SSS_ADDR_W 16
`define SSS_ST_IDLE 2'h0
`define SSS_ST_GRANTED 2'h1
`define SSS_ST_IGNORED 2'h2
`define SSS_ST_FINISH 2'h3
`define SSS_SEM_FREE 2'h0
`define SSS_SEM_CPU 2'h1
`define SSS_SEM_SLAVE 2'h2
`define SSS_RST_BYTE 8'h00
`define SSS_RST_CNT 15'h0000
`endif

// File: test/sss_spi_slave_properties.sv
// Checker of semaphore, event and pin behaviour of the SPI slave
`timescale 1ns/10ps
module sss_spi_slave_chk (
   input wire CORE_CLK,
   input wire NRST,
   input wire ENABLE,
   input wire TASK_ACQUIRE,
   input wire TASK_RELEASE,
   input wire CLEAR_RX_EXCESS,
   input wire CSN,
   input wire MISO_OE,
   input wire MEM_RD,
   input wire MEM_WR,
   input wire [7:0] MEM_WDATA,
   input wire MEM_ACK,
   input wire EVENT_END,
   input wire EVENT_ACQUIRED,
   input wire RX_BUFFER_FULL_EVENT,
   input wire [1:0] SEM_STATUS,
   input wire TX_EXCESS_FLAG,
   input wire RX_EXCESS_FLAG
);
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (!NRST);
   // Semaphore ownership and task answers
   enable_quiet_a: assert property ($rose(ENABLE) |=> !EVENT_ACQUIRED [*3])
      else $error("grant event at enable");
   acq_now_a: assert property (TASK_ACQUIRE && ENABLE && SEM_STATUS == 2'h1 |=> EVENT_ACQUIRED)
      else $error("acquire by owner not answered");
   release_cpu_a: assert property (TASK_RELEASE && !TASK_ACQUIRE && ENABLE && CSN && SEM_STATUS == 2'h1
      |=> ##1 SEM_STATUS == 2'h0)
      else $error("release not taken");
   release_noop_a: assert property (TASK_RELEASE && !TASK_ACQUIRE && CSN && SEM_STATUS == 2'h0
      |=> SEM_STATUS != 2'h1)
      else $error("release without ownership acted");
   acq_cpu_a: assert property (EVENT_ACQUIRED |-> ##[0:2] SEM_STATUS == 2'h1)
      else $error("grant event without ownership");
   // Pin, memory, transaction end and excess flag behaviour
   miso_hiz_a: assert property (CSN [*5] |-> !MISO_OE)
      else $error("data out driven while unselected");
   wr_owned_a: assert property (MEM_WR |-> SEM_STATUS == 2'h2)
      else $error("write without semaphore");
   req_hold_a: assert property (MEM_WR && !MEM_ACK |=> MEM_WR && $stable(MEM_WDATA))
      else $error("write request dropped");
   end_drained_a: assert property (EVENT_END |-> !MEM_WR && !MEM_RD)
      else $error("end before memory drained");
   end_release_a: assert property (EVENT_END |=> ##[0:2] SEM_STATUS != 2'h2)
      else $error("semaphore kept after end");
   flag_clear_a: assert property ($fell(RX_EXCESS_FLAG) |-> $past(CLEAR_RX_EXCESS))
      else $error("flag fell without clear");
   cover property (EVENT_END);
   cover property (RX_BUFFER_FULL_EVENT);
   cover property ($rose(TX_EXCESS_FLAG));
   cover property (EVENT_ACQUIRED);
endmodule // sss_spi_slave_chk

// File: test/sss_spi_master.sv
// Behavioural SPI master that frames bytes for the slave
`timescale 1ns/10ps
module sss_spi_master (
   input wire CPOL,
   input wire CPHA,
   input wire LSB_FIRST,
   output reg CSN,
   output reg SCK,
   output reg MOSI,
   input wire MISO
);
   reg [7:0] tx [0:7];
   reg [7:0] rx [0:7];
   integer i;
   integer b;
   // Idle levels before the first frame
   initial begin
      CSN = 1'b1;
      SCK = 1'b0;
      MOSI = 1'b0;
   end
   // One frame of n bytes, sampling and shifting on the mode's edges
   task xfer(input integer n);
      begin
         SCK = CPOL;
         #537 CSN = 1'b0;
         #1000;
         for (i = 0; i < n; i = i + 1) begin
            for (b = 0; b < 8; b = b + 1) begin
               if (!CPHA) MOSI = tx[i][LSB_FIRST ? b : 7 - b];
               #400 SCK = ~SCK;
               if (CPHA) MOSI = tx[i][LSB_FIRST ? b : 7 - b];
               else rx[i][LSB_FIRST ? b : 7 - b] = MISO;
               #400 SCK = ~SCK;
               if (CPHA) rx[i][LSB_FIRST ? b : 7 - b] = MISO;
            end
         end
         #400 CSN = 1'b1;
         // Released data line no longer holds its last bit
         MOSI = ~MOSI;
      end
   endtask
endmodule // sss_spi_master

// File: test/sss_spi_slave_test.sv
// Self-checking bench of the SPI slave with semaphore and memory access
`timescale 1ns/10ps
module sss_spi_slave_test;
   reg CORE_CLK = 1'b0, NRST = 1'b0, ENABLE = 1'b0, CPOL = 1'b1, CPHA = 1'b1, LSB_FIRST = 1'b0;
   reg END_ACQUIRE = 1'b0, TASK_ACQUIRE = 1'b0, TASK_RELEASE = 1'b0, MEM_ACK = 1'b0;
   reg CLEAR_TX_EXCESS = 1'b0, CLEAR_RX_EXCESS = 1'b0;
   reg [15:0] RX_BUFFER_POINTER = 16'h0040, TX_BUFFER_POINTER = 16'h0010;
   reg [14:0] RX_BUFFER_LIMIT = 15'h0003, TX_BUFFER_LIMIT = 15'h0002;
   reg [7:0] IGNORED_FILL_CHARACTER = 8'h5A, TX_EXCESS_FLAG_FILL_CHARACTER = 8'hE7, MEM_RDATA = 8'h00;
   wire CSN, SCK, MOSI, MISO_OUT, MISO_OE, MEM_RD, MEM_WR, EVENT_END, EVENT_ACQUIRED, RX_BUFFER_FULL_EVENT;
   wire TX_EXCESS_FLAG, RX_EXCESS_FLAG;
   wire [15:0] MEM_ADDR;
   wire [7:0] MEM_WDATA;
   wire [1:0] SEM_STATUS;
   wire [14:0] RX_BYTE_COUNTER, TX_BYTE_COUNTER;
   wire miso_pin = MISO_OE ? MISO_OUT : 1'bz;
   reg [7:0] mem [0:255];
   integer miscompares = 0, n_tests = 0, n_end = 0, n_acq = 0, n_full = 0, i, m;
   sss_spi_slave uut (.*);
   sss_spi_master mst (.CPOL(CPOL), .CPHA(CPHA), .LSB_FIRST(LSB_FIRST), .CSN(CSN), .SCK(SCK), .MOSI(MOSI),
      .MISO(miso_pin));
   initial forever #50 CORE_CLK = ~CORE_CLK;
   // RAM answers each request one cycle later; events are counted
   always @(posedge CORE_CLK) begin
      MEM_ACK <= (MEM_RD | MEM_WR) & ~MEM_ACK;
      MEM_RDATA <= mem[MEM_ADDR[7:0]];
      if (MEM_WR & ~MEM_ACK) mem[MEM_ADDR[7:0]] <= MEM_WDATA;
      if (EVENT_END) n_end <= n_end + 1;
      if (EVENT_ACQUIRED) n_acq <= n_acq + 1;
      if (RX_BUFFER_FULL_EVENT) n_full <= n_full + 1;
   end
   task chk(input [15:0] got, input [15:0] exp);
      begin
         n_tests = n_tests + 1;
         if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   // Waits a bounded time for the next end event
   task wait_end(input integer n0);
      begin
         for (i = 0; i < 300 && n_end == n0; i = i + 1) @(posedge CORE_CLK);
         repeat (4) @(posedge CORE_CLK);
      end
   endtask
   task report_and_stop;
      begin
         $display("Checks %0d, mismatches %0d", n_tests, miscompares);
         if (miscompares == 0 && n_tests > 0) $display("[ PASS ]");
         else $display("[ FAIL ]");
         $finish;
      end
   endtask
   initial begin
      #2000000;
      miscompares = miscompares + 1;
      report_and_stop;
   end
   // Main sequence
   initial begin
      for (i = 0; i < 256; i = i + 1) mem[i] = i[7:0] ^ 8'hA5;
      repeat (2) @(posedge CORE_CLK);
      NRST <= 1'b1;
      repeat (2) @(posedge CORE_CLK);
      ENABLE <= 1'b1;
      repeat (6) @(posedge CORE_CLK);
      chk(16'(SEM_STATUS), 16'h0001);
      chk(16'(n_acq), 16'h0000);
      // CPU owns the semaphore, so this frame is ignored
      mst.xfer(2);
      wait_end(0);
      chk(16'(n_end), 16'h0000);
      chk({mst.rx[0], mst.rx[1]}, 16'h5A5A);
      chk(16'(mem[64]), 16'h00E5);
      TASK_ACQUIRE <= 1'b1;
      @(posedge CORE_CLK);
      TASK_ACQUIRE <= 1'b0;
      repeat (3) @(posedge CORE_CLK);
      chk(16'(n_acq), 16'h0001);
      // Three releases in a row: the later ones find no owner
      TASK_RELEASE <= 1'b1;
      repeat (3) @(posedge CORE_CLK);
      TASK_RELEASE <= 1'b0;
      repeat (3) @(posedge CORE_CLK);
      chk(16'(SEM_STATUS), 16'h0000);
      // Granted frames in every mode, one byte over the receive limit and two over the transmit limit
      for (m = 0; m < 4; m = m + 1) begin
         {CPOL, CPHA, LSB_FIRST} <= {m[1], m[0], m[0]};
         for (i = 0; i < 4; i = i + 1) mst.tx[i] = {i[3:0], m[3:0]};
         repeat (4) @(posedge CORE_CLK);
         mst.xfer(4);
         wait_end(n_end);
         chk(16'(n_end), 16'(m + 1));
         chk(16'(n_full), 16'(m + 1));
         chk({mem[64], mem[65]}, {mst.tx[0], mst.tx[1]});
         chk({mem[66], mem[67]}, {mst.tx[2], 8'hE6});
         chk({RX_BYTE_COUNTER[7:0], TX_BYTE_COUNTER[7:0]}, 16'h0302);
         chk({14'h0, TX_EXCESS_FLAG, RX_EXCESS_FLAG}, 16'h0003);
         chk({mst.rx[0], mst.rx[1]}, {mem[16], mem[17]});
         chk({mst.rx[2], mst.rx[3]}, 16'hE7E7);
         chk(16'(SEM_STATUS), 16'h0000);
         CLEAR_TX_EXCESS <= 1'b1;
         CLEAR_RX_EXCESS <= 1'b1;
         @(posedge CORE_CLK);
         CLEAR_TX_EXCESS <= 1'b0;
         CLEAR_RX_EXCESS <= 1'b0;
         repeat (2) @(posedge CORE_CLK);
         chk({14'h0, TX_EXCESS_FLAG, RX_EXCESS_FLAG}, 16'h0000);
      end
      // Shortcut on and the CPU asks mid-frame: a single grant after the end
      END_ACQUIRE <= 1'b1;
      TX_BUFFER_LIMIT <= 15'h0003;
      fork
         mst.xfer(2);
         begin
            repeat (40) @(posedge CORE_CLK);
            TASK_ACQUIRE <= 1'b1;
            @(posedge CORE_CLK);
            TASK_ACQUIRE <= 1'b0;
            repeat (3) @(posedge CORE_CLK);
            chk(16'(n_acq), 16'h0001);
         end
      join
      wait_end(4);
      chk(16'(n_acq), 16'h0002);
      chk(16'(SEM_STATUS), 16'h0001);
      chk({RX_BYTE_COUNTER[7:0], TX_BYTE_COUNTER[7:0]}, 16'h0202);
      chk({14'h0, TX_EXCESS_FLAG, RX_EXCESS_FLAG}, 16'h0000);
      report_and_stop;
   end
endmodule // sss_spi_slave_test
bind sss_spi_slave sss_spi_slave_chk chk (.*);
